// >>> dv/pcc_pkt_source.sv
`timescale 1ns/1ps
// ==========================================
// far-side byte source: back-to-back bytes; for errEvery above 0 the first and every errEvery-th after it errored, none for 0
module pcc_pkt_source (
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic        start,
	input  wire logic [17:0] count,
	input  wire logic [3:0]  errEvery,
	output logic             byteValid,
	output logic             byteErr,
	output logic             busy
);
	logic [17:0] left;
	logic [3:0]  phase;
	logic        tog;
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			left  <= 18'h0;
			phase <= 4'h0;
			tog   <= 1'b0;
		end else begin
			tog <= ~tog;
			if (start) begin
				left  <= count;
				phase <= 4'h0;
			end else if (busy) begin
				left  <= left - 18'h1;
				phase <= (phase + 4'h1 == errEvery) ? 4'h0 : phase + 4'h1;
			end
		end
	end
	assign busy      = left != 18'h0;
	assign byteValid = busy;
	// idle error line toggles, so a design that reads it unqualified is caught
	assign byteErr   = busy ? (errEvery != 4'h0 && phase == 4'h0) : tog;
endmodule // pcc_pkt_source

// >>> dv/pcc_top_tb.sv
`timescale 1ns/1ps
module pcc_top_tb import pcc_pkg::*; ;
	typedef struct packed {
		logic [9:0]  idx;
		logic [31:0] wd;
		logic        wr;
		logic [31:0] exp;
	} pcc_row_t;
	logic        ref_clk;
	logic        resetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic [31:0] hrdata;
	logic        hresp;
	logic        chkByteValid;
	logic        chkByteErr;
	logic        irq;
	logic        srcStart;
	logic [17:0] srcCount;
	logic [3:0]  srcErrEvery;
	logic        srcBusy;
	int          n_fail;
	int          comparisons;
	// ==========================================
	// ordinary register cases: write if asked, then read back
	pcc_row_t rows [13] = '{
		'{IDX_PKTLEN, 32'h0, 1'b0, 32'h5dc},
		'{IDX_TOTAL, 32'h0, 1'b0, 32'h0},
		'{IDX_ERRCTL, 32'h0, 1'b0, 32'h0},
		'{IDX_CTRL, 32'h0, 1'b0, 32'h0},
		'{IDX_IRQSTAT, 32'h0, 1'b0, 32'h0},
		'{IDX_IRQMASK, 32'h0, 1'b0, 32'h0},
		'{IDX_PKTLEN, 32'hffff0001, 1'b1, 32'h1},
		'{IDX_TOTAL, 32'h1234, 1'b1, 32'h0},
		'{10'h3ff, 32'hffffffff, 1'b1, 32'h0},
		'{IDX_CTRL, 32'h3, 1'b1, 32'h3},
		'{IDX_IRQMASK, 32'h5, 1'b1, 32'h5},
		'{IDX_IRQMASK, 32'h0, 1'b1, 32'h0},
		'{IDX_CTRL, 32'h1, 1'b1, 32'h1}
	};
	pcc_top pcc_top_i (
		.ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .chkByteValid(chkByteValid), .chkByteErr(chkByteErr), .irq(irq)
	);
	pcc_pkt_source pcc_pkt_source_i (
		.ref_clk(ref_clk), .resetn(resetn), .start(srcStart), .count(srcCount),
		.errEvery(srcErrEvery), .byteValid(chkByteValid), .byteErr(chkByteErr), .busy(srcBusy)
	);
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// ==========================================
	// helpers
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
			n_fail++;
		end
	endtask
	// ready and read data sampled at the negedge before the edge, race-free
	task automatic bus(input logic wr, input logic [9:0] idx, input logic [31:0] wd, output logic [31:0] rd);
		int n;
		logic r;
		n = 0;
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {20'h0, idx, 2'h0};
		do begin
			@(negedge ref_clk);
			r = hreadyout;
			@(posedge ref_clk);
			n++;
		end while (r !== 1'b1 && n < 20);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do begin
			@(negedge ref_clk);
			r = hreadyout;
			rd = hrdata;
			@(posedge ref_clk);
			n++;
		end while (r !== 1'b1 && n < 20);
		if (n >= 20) begin
			check("bus ready", 32'h1, 32'h0);
			finish_test();
		end
	endtask
	task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
		logic [31:0] d;
		bus(1'b1, idx, wd, d);
	endtask
	task automatic rdc(input string name, input logic [9:0] idx, input logic [31:0] exp);
		logic [31:0] d;
		bus(1'b0, idx, 32'h0, d);
		check(name, exp, d);
		check("hresp", 32'h0, {31'h0, hresp});
	endtask
	task automatic irqchk(input logic e);
		@(negedge ref_clk);
		check("irq", {31'h0, e}, {31'h0, irq});
		@(posedge ref_clk);
	endtask
	task automatic send(input logic [17:0] cnt, input logic [3:0] every);
		int n;
		n = 0;
		srcStart <= 1'b1;
		srcCount <= cnt;
		srcErrEvery <= every;
		@(posedge ref_clk);
		srcStart <= 1'b0;
		do begin
			@(negedge ref_clk);
			n++;
		end while (srcBusy !== 1'b0 && n < 70000);
		@(posedge ref_clk);
		if (n >= 70000) begin
			check("source done", 32'h1, 32'h0);
			finish_test();
		end
	endtask
	// ==========================================
	// main sequence
	initial begin
		n_fail = 0;
		comparisons = 0;
		resetn <= 1'b0;
		hsel <= 1'b0;
		haddr <= 32'h0;
		htrans <= 2'h0;
		hwrite <= 1'b0;
		hwdata <= 32'h0;
		srcStart <= 1'b0;
		srcCount <= 18'h0;
		srcErrEvery <= 4'h0;
		repeat (5) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		foreach (rows[i]) begin
			if (rows[i].wr) wr(rows[i].idx, rows[i].wd);
			rdc("table", rows[i].idx, rows[i].exp);
		end
		$display("test table done");
		send(18'd10, 4'd3);
		rdc("total before lock", IDX_TOTAL, 32'h0);
		wr(IDX_ERRCTL, 32'h1);
		rdc("total", IDX_TOTAL, 32'ha);
		rdc("errored", IDX_ERRCTL, 32'h4);
		send(18'd5, 4'd3);
		rdc("total held", IDX_TOTAL, 32'ha);
		wr(IDX_ERRCTL, 32'h2);
		rdc("total locked", IDX_TOTAL, 32'hf);
		rdc("errored locked", IDX_ERRCTL, 32'h6);
		wr(IDX_ERRCTL, 32'h1);
		rdc("total cleared", IDX_TOTAL, 32'h0);
		$display("test lock done");
		send(18'd65540, 4'd1);
		wr(IDX_ERRCTL, 32'h1);
		rdc("total sat", IDX_TOTAL, 32'hffff);
		rdc("errored sat", IDX_ERRCTL, 32'h6ff);
		rdc("irq status", IDX_IRQSTAT, 32'h7);
		irqchk(1'b0);
		wr(IDX_IRQMASK, 32'h3);
		irqchk(1'b1);
		wr(IDX_IRQSTAT, 32'h3);
		irqchk(1'b0);
		rdc("irq status w1c", IDX_IRQSTAT, 32'h4);
		$display("test saturate done");
		wr(IDX_CTRL, 32'h3);
		send(18'd3, 4'd1);
		wr(IDX_ERRCTL, 32'h1);
		rdc("total wrap", IDX_TOTAL, 32'h2);
		rdc("errored wrap", IDX_ERRCTL, 32'h602);
		wr(IDX_ERRCTL, 32'h2);
		rdc("flags cleared", IDX_ERRCTL, 32'h2);
		$display("test wrap done");
		// checker off: bytes must be refused
		wr(IDX_CTRL, 32'h2);
		send(18'd4, 4'd1);
		wr(IDX_ERRCTL, 32'h1);
		rdc("total disabled", IDX_TOTAL, 32'h0);
		rdc("errored disabled", IDX_ERRCTL, 32'h0);
		$display("test disabled done");
		// ==========================================
		// mid-run reset: settings go back to reset values
		resetn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		rdc("pktlen after reset", IDX_PKTLEN, 32'h5dc);
		rdc("errctl after reset", IDX_ERRCTL, 32'h0);
		rdc("ctrl after reset", IDX_CTRL, 32'h0);
		irqchk(1'b0);
		$display("test reset done");
		finish_test();
	end
endmodule // pcc_top_tb

// >>> hdl/pcc_ahb_slave.sv
`timescale 1ns/1ps
module pcc_ahb_slave import pcc_pkg::*; (
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	pcc_reg_if.slave         bus
);
	// ==========================================
	// address phase capture
	pcc_bus_state_t state_reg;
	pcc_bus_state_t state_next;
	logic           writeLat_reg;
	logic [9:0]     addrLat_reg;
	wire            accept = hsel & htrans[1] & hready;

	assign state_next = (state_reg == ST_IDLE) ? (accept ? ST_WAIT : ST_IDLE) : ST_IDLE;
	assign bus.wrEn   = (state_reg == ST_WAIT) & writeLat_reg;
	assign bus.addr   = addrLat_reg;
	assign bus.wdata  = hwdata;

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg    <= ST_IDLE;
			writeLat_reg <= 1'b0;
			addrLat_reg  <= 10'h000;
		end else begin
			state_reg <= state_next;
			if (state_reg == ST_IDLE && accept) begin
				writeLat_reg <= hwrite;
				addrLat_reg  <= haddr[ADDR_IDX_MSB:ADDR_IDX_LSB];
			end
		end
	end

	// ==========================================
	// data phase: one wait state so hrdata comes from a flop
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			hreadyout <= 1'b1;
			hrdata    <= 32'h0000_0000;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= (state_next == ST_IDLE);
			hresp     <= 1'b0;
			if (state_reg == ST_WAIT && !writeLat_reg) begin
				hrdata <= bus.rdata;
			end
		end
	end

	sequence s_taken;
		(state_reg == ST_IDLE) && accept;
	endsequence
	sequence s_one_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	a_bus_one_wait: assert property (@(posedge ref_clk) disable iff (!resetn)
		s_taken |=> s_one_wait) else $error("bus answer not after one wait state");
endmodule // pcc_ahb_slave

// >>> hdl/pcc_counters.sv
`timescale 1ns/1ps
module pcc_counters import pcc_pkg::*; (
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic        enable,
	input  wire logic        mode,
	input  wire logic        byteValid,
	input  wire logic        byteErr,
	input  wire logic [15:0] pktLen,
	input  wire logic        clear,
	output logic [15:0]      totalCnt,
	output logic [7:0]       errCnt,
	output logic             byteOvf,
	output logic             pktOvf,
	output logic             byteOvfEvt,
	output logic             pktOvfEvt
);
	// ==========================================
	// next-value decode
	logic [15:0] pktCnt_reg;
	logic [15:0] pktByte_reg;
	wire         countByte = enable & byteValid;
	wire         countErr  = countByte & byteErr;
	wire         pktDone   = countByte & (16'(pktByte_reg + 16'h0001) >= pktLen);
	wire         errAtMax  = (errCnt == ERR_MAX);
	wire         pktAtMax  = (pktCnt_reg == PKT_MAX);
	assign byteOvfEvt = countByte & (totalCnt == TOTAL_MAX);
	assign pktOvfEvt  = pktDone & pktAtMax;

	// single mode holds at max, continuous mode wraps
	wire [15:0] totalNext = (byteOvfEvt && !mode) ? totalCnt : 16'(totalCnt + 16'h0001);
	wire [7:0]  errNext   = (errAtMax && !mode) ? errCnt : 8'(errCnt + 8'h01);
	wire [15:0] pktNext   = (pktAtMax && !mode) ? pktCnt_reg : 16'(pktCnt_reg + 16'h0001);

	// ==========================================
	// counters; a byte arriving with clear is dropped
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			totalCnt    <= 16'h0000;
			errCnt      <= 8'h00;
			pktCnt_reg  <= 16'h0000;
			pktByte_reg <= 16'h0000;
		end else if (clear) begin
			totalCnt    <= 16'h0000;
			errCnt      <= 8'h00;
			pktCnt_reg  <= 16'h0000;
			pktByte_reg <= 16'h0000;
		end else begin
			if (countByte) totalCnt <= totalNext;
			if (countErr) errCnt <= errNext;
			if (pktDone) pktCnt_reg <= pktNext;
			if (countByte) pktByte_reg <= pktDone ? 16'h0000 : 16'(pktByte_reg + 16'h0001);
		end
	end

	// overflow event wins over a clear in the same cycle
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			byteOvf <= 1'b0;
			pktOvf  <= 1'b0;
		end else begin
			byteOvf <= byteOvfEvt | (byteOvf & ~clear);
			pktOvf  <= pktOvfEvt | (pktOvf & ~clear);
		end
	end

	a_total_count_up: assert property (@(posedge ref_clk) disable iff (!resetn)
		countByte && !clear && totalCnt != TOTAL_MAX |=> totalCnt == 16'($past(totalCnt) + 16'h0001))
		else $error("total byte count did not advance");
	a_total_sat_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
		!mode && !clear && totalCnt == TOTAL_MAX |=> totalCnt == TOTAL_MAX)
		else $error("total byte count left its maximum in single mode");
	a_err_count_up: assert property (@(posedge ref_clk) disable iff (!resetn)
		countErr && !clear && !errAtMax |=> errCnt == 8'($past(errCnt) + 8'h01))
		else $error("errored byte count did not advance");
	a_err_sat_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
		!mode && !clear && errAtMax |=> errCnt == ERR_MAX)
		else $error("errored byte count left its maximum in single mode");
	a_byte_ovf_sticky: assert property (@(posedge ref_clk) disable iff (!resetn)
		byteOvfEvt |=> byteOvf ##1 (byteOvf || $past(clear)))
		else $error("byte overflow flag not set or not held");
	a_pkt_ovf_set: assert property (@(posedge ref_clk) disable iff (!resetn)
		pktOvfEvt |=> pktOvf)
		else $error("packet overflow flag not set");
	a_ovf_cleared: assert property (@(posedge ref_clk) disable iff (!resetn)
		clear && !byteOvfEvt && !pktOvfEvt |=> !byteOvf && !pktOvf && totalCnt == 16'h0000)
		else $error("overflow flags survived a clear");
	a_total_wraps: assert property (@(posedge ref_clk) disable iff (!resetn)
		mode && countByte && !clear && totalCnt == TOTAL_MAX |=> totalCnt == 16'h0000 && byteOvf)
		else $error("total byte count did not wrap in continuous mode");
endmodule // pcc_counters

// >>> hdl/pcc_top.sv
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
module pcc_top import pcc_pkg::*; (
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	input  wire logic        chkByteValid,
	input  wire logic        chkByteErr,
	output logic             irq
);
	// ==========================================
	// register bus
	pcc_reg_if bus ();

	pcc_ahb_slave u_slave (
		.ref_clk   (ref_clk),
		.resetn    (resetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hwdata    (hwdata),
		.hready    (hready),
		.hreadyout (hreadyout),
		.hrdata    (hrdata),
		.hresp     (hresp),
		.bus       (bus.slave)
	);

	function automatic logic hitIdx(input logic [9:0] a, input logic [9:0] idx);
		return a == idx;
	endfunction

	// ==========================================
	// decode
	logic [1:0]       ctrl_reg;
	logic [15:0]      pktLen_reg;
	logic [15:0]      snapTotal_reg;
	logic [7:0]       snapErr_reg;
	logic [IRQ_W-1:0] irqStat_reg;
	logic [IRQ_W-1:0] irqMask_reg;
	logic [IRQ_W-1:0] irqStat_next;
	logic [15:0]      liveTotal;
	logic [7:0]       liveErr;
	logic             byteOvf;
	logic             pktOvf;
	logic             byteOvfEvt;
	logic             pktOvfEvt;

	wire selCtrl    = hitIdx(bus.addr, IDX_CTRL);
	wire selTotal   = hitIdx(bus.addr, IDX_TOTAL);
	wire selErr     = hitIdx(bus.addr, IDX_ERRCTL);
	wire selPktLen  = hitIdx(bus.addr, IDX_PKTLEN);
	wire selIrqStat = hitIdx(bus.addr, IDX_IRQSTAT);
	wire selIrqMask = hitIdx(bus.addr, IDX_IRQMASK);
	wire wrErr      = bus.wrEn & selErr;
	wire lockPulse  = wrErr & bus.wdata[ERR_LOCK_BIT];
	wire clearPulse = wrErr & bus.wdata[ERR_CLEAR_BIT];
	wire takeSnap   = lockPulse | clearPulse;
	wire errEvt     = ctrl_reg[CTRL_EN_BIT] & chkByteValid & chkByteErr;
	wire [IRQ_W-1:0] irqEvents = {errEvt, pktOvfEvt, byteOvfEvt};
	wire [IRQ_W-1:0] irqW1c    = (bus.wrEn & selIrqStat) ? bus.wdata[IRQ_W-1:0] : {IRQ_W{1'b0}};
	// events win over a write-one-to-clear in the same cycle
	assign irqStat_next = irqEvents | (irqStat_reg & ~irqW1c);

	wire [31:0] errWord = {21'h000000, pktOvf, byteOvf, 1'b0, snapErr_reg};
	// count reads show the last snapshot so the pair stays coherent
	assign bus.rdata = selTotal   ? {16'h0000, snapTotal_reg} :
	                   selErr     ? errWord :
	                   selPktLen  ? {16'h0000, pktLen_reg} :
	                   selCtrl    ? {30'h00000000, ctrl_reg} :
	                   selIrqStat ? {29'h00000000, irqStat_reg} :
	                   selIrqMask ? {29'h00000000, irqMask_reg} :
	                   32'h0000_0000;

	// ==========================================
	// counters
	pcc_counters u_cnt (
		.ref_clk    (ref_clk),
		.resetn     (resetn),
		.enable     (ctrl_reg[CTRL_EN_BIT]),
		.mode       (ctrl_reg[CTRL_MODE_BIT]),
		.byteValid  (chkByteValid),
		.byteErr    (chkByteErr),
		.pktLen     (pktLen_reg),
		.clear      (clearPulse),
		.totalCnt   (liveTotal),
		.errCnt     (liveErr),
		.byteOvf    (byteOvf),
		.pktOvf     (pktOvf),
		.byteOvfEvt (byteOvfEvt),
		.pktOvfEvt  (pktOvfEvt)
	);

	// ==========================================
	// software registers
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_reg   <= CTRL_RST;
			pktLen_reg <= PKTLEN_RST;
		end else if (bus.wrEn) begin
			if (selCtrl) ctrl_reg <= bus.wdata[1:0];
			if (selPktLen) pktLen_reg <= bus.wdata[15:0];
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			snapTotal_reg <= 16'h0000;
			snapErr_reg   <= 8'h00;
		end else if (takeSnap) begin
			snapTotal_reg <= liveTotal;
			snapErr_reg   <= liveErr;
		end
	end

	// ==========================================
	// interrupts; irq lags status by one cycle
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			irqStat_reg <= IRQ_RST;
			irqMask_reg <= IRQ_RST;
			irq         <= 1'b0;
		end else begin
			irqStat_reg <= irqStat_next;
			if (bus.wrEn && selIrqMask) irqMask_reg <= bus.wdata[IRQ_W-1:0];
			irq <= |(irqStat_reg & irqMask_reg);
		end
	end

	a_snap_on_lock: assert property (@(posedge ref_clk) disable iff (!resetn)
		lockPulse |=> snapTotal_reg == $past(liveTotal) && snapErr_reg == $past(liveErr))
		else $error("snapshot not taken on lock write");
	a_snap_held: assert property (@(posedge ref_clk) disable iff (!resetn)
		!takeSnap |=> $stable(snapTotal_reg) && $stable(snapErr_reg))
		else $error("snapshot changed without a lock write");
	a_lock_clear: assert property (@(posedge ref_clk) disable iff (!resetn)
		clearPulse |=> liveTotal == 16'h0000 && liveErr == 8'h00 && snapTotal_reg == $past(liveTotal))
		else $error("lock-and-clear did not latch and clear");
	a_pktlen_write: assert property (@(posedge ref_clk) disable iff (!resetn)
		bus.wrEn && selPktLen |=> pktLen_reg == $past(bus.wdata[15:0]))
		else $error("packet length not written");
	a_ovf_irq_path: assert property (@(posedge ref_clk) disable iff (!resetn)
		byteOvfEvt && irqMask_reg[IRQ_BYTE_OVF] && !(bus.wrEn && (selIrqMask || selIrqStat)) |=> ##1 irq)
		else $error("byte overflow did not raise irq");
endmodule // pcc_top

// >>> pkg/pcc_pkg.sv
package pcc_pkg;
	// ==========================================
	// register word indices (byte address = index * 4)
	localparam logic [9:0]  IDX_CTRL       = 10'h016;
	localparam logic [9:0]  IDX_TOTAL      = 10'h071;
	localparam logic [9:0]  IDX_ERRCTL     = 10'h072;
	localparam logic [9:0]  IDX_PKTLEN     = 10'h07b;
	localparam logic [9:0]  IDX_IRQSTAT    = 10'h080;
	localparam logic [9:0]  IDX_IRQMASK    = 10'h081;
	localparam int          ADDR_IDX_LSB   = 2;
	localparam int          ADDR_IDX_MSB   = 11;
	// ==========================================
	// field positions
	localparam int          CTRL_EN_BIT    = 0;
	localparam int          CTRL_MODE_BIT  = 1;
	localparam int          ERR_LOCK_BIT   = 0;
	localparam int          ERR_CLEAR_BIT  = 1;
	localparam int          BYTE_OVF_BIT   = 9;
	localparam int          PKT_OVF_BIT    = 10;
	localparam int          IRQ_BYTE_OVF   = 0;
	localparam int          IRQ_PKT_OVF    = 1;
	localparam int          IRQ_ERR_BYTE   = 2;
	localparam int          IRQ_W          = 3;
	// ==========================================
	// reset values and limits
	localparam logic [15:0] PKTLEN_RST     = 16'h05dc;
	localparam logic [1:0]  CTRL_RST       = 2'h0;
	localparam logic [15:0] TOTAL_MAX      = 16'hffff;
	localparam logic [7:0]  ERR_MAX        = 8'hff;
	localparam logic [15:0] PKT_MAX        = 16'hffff;
	localparam logic [2:0]  IRQ_RST        = 3'h0;
	// ==========================================
	// bus slave states
	typedef enum logic [0:0] {ST_IDLE, ST_WAIT} pcc_bus_state_t;
endpackage

// >>> pkg/pcc_reg_if.sv
`timescale 1ns/1ps
interface pcc_reg_if;
	logic        wrEn;
	logic [9:0]  addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	modport slave (output wrEn, output addr, output wdata, input rdata);
	modport regs  (input wrEn, input addr, input wdata, output rdata);
endinterface
